// File: hdl/bank_route.sv
`timescale 1ns/1ps
`default_nettype none
`include "bank_sel_regs.svh"
// Combinational slot lookup; registered by the caller.
module bank_route (
  // Active selection and logical address
  input wire logic [15:0] sel,
  input wire logic [14:0] log_addr,
  // Routed physical address
  output logic [16:0] phys_addr
);
  import bank_sel_pkg::*;

  function automatic mod_num_t slot_mod(input sel_word_t s, input logic [1:0] slot);
    slot_mod = s[slot*`MOD_NUM_W +: `MOD_NUM_W];
  endfunction

  always_comb begin
    phys_addr = {slot_mod(sel, log_addr[`LOG_ADDR_W-1 -: `SLOT_W]),
                 log_addr[`MOD_WORDS_LOG2-1:0]}; // RULE_09
  end
endmodule
`default_nettype wire

// File: hdl/bank_sel_pkg.sv
package bank_sel_pkg;
  typedef logic [3:0] mod_num_t;
  typedef logic [15:0] sel_word_t;
  typedef logic [5:0] level_t;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_LOAD_SEL,
    OP_SWAP_MOD,
    OP_SET_SLOT
  } sel_op_t;
endpackage

// File: hdl/bank_sel_regs.svh
`ifndef BANK_SEL_REGS_SVH
`define BANK_SEL_REGS_SVH

// Memory geometry.
`define MOD_WORDS_LOG2 13
`define MOD_NUM_W 4
`define SLOT_W 2
`define SLOTS 4
`define LEVEL_W 6
`define LEVELS 64
`define PHYS_ADDR_W 17
`define LOG_ADDR_W 15
`define SEL_W 16
// Reset selection: slots 0..3 map to modules 0..3.
`define SEL_RESET 16'h3210

`endif

// File: hdl/bank_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "bank_sel_regs.svh"
// How it works
// RULE_01: 131,072 words of 32 bits total.
// RULE_02: Four modules connected during each instruction.
// RULE_03: Load instruction writes bank assignment register.
// RULE_04: Each level keeps its own selection.
// RULE_05: Selection saved on leave, restored on return.
// RULE_06: Up to sixteen modules of 8192 words.
// RULE_07: Two adjustment instructions replace failed modules.
// RULE_08: Sixty-four levels, each with saved selection.
// RULE_09: Upper address bits pick slot, then module.
module bank_select (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Instruction side
  input wire bank_sel_pkg::sel_op_t op,
  input wire logic [15:0] op_data,
  input wire logic [3:0] op_old_mod,
  input wire logic [3:0] op_new_mod,
  input wire logic [1:0] op_slot,
  // Level switch
  input wire logic level_switch,
  input wire bank_sel_pkg::level_t new_level,
  // Memory access
  input wire logic acc_req,
  input wire logic [14:0] acc_addr,
  // Outputs
  output logic [16:0] mem_addr,
  output logic mem_req,
  output logic [15:0] active_sel,
  output logic [5:0] cur_level
);
  import bank_sel_pkg::*;

  // Save area per level; a real machine keeps it in main memory, here it is local.
  sel_word_t save_mem [`LEVELS];
  logic [`LEVELS-1:0] saved_ok, next_saved_ok;
  sel_word_t sel, next_sel;
  level_t level, next_level;
  logic [16:0] routed, next_mem_addr;
  logic next_mem_req;
  logic save_we;

  bank_route u_route (
    .sel(sel),
    .log_addr(acc_addr),
    .phys_addr(routed)
  );

  function automatic sel_word_t swap_mod(input sel_word_t s, input mod_num_t o,
                                         input mod_num_t n);
    sel_word_t r;
    r = s;
    for (int i = 0; i < `SLOTS; i++) begin
      if (s[i*`MOD_NUM_W +: `MOD_NUM_W] == o) begin
        r[i*`MOD_NUM_W +: `MOD_NUM_W] = n;
      end
    end
    return r;
  endfunction

  always_comb begin
    next_sel = sel;
    next_level = level;
    save_we = 1'b0;
    next_saved_ok = saved_ok;
    // A switch to another level wins over any instruction in the same cycle; the instruction is dropped.
    if (level_switch && new_level != level) begin
      save_we = 1'b1; // RULE_05
      next_saved_ok[level] = 1'b1; // RULE_05
      next_sel = saved_ok[new_level] ? save_mem[new_level] : `SEL_RESET; // RULE_05 RULE_04
      next_level = new_level; // RULE_08
    end else begin
      unique case (op)
        OP_NONE: next_sel = sel;
        OP_LOAD_SEL: next_sel = op_data; // RULE_03
        OP_SWAP_MOD: next_sel = swap_mod(sel, op_old_mod, op_new_mod); // RULE_07
        OP_SET_SLOT: begin
          next_sel[op_slot*`MOD_NUM_W +: `MOD_NUM_W] = op_new_mod; // RULE_07 RULE_06
        end
      endcase
    end
    next_mem_addr = routed; // RULE_01 RULE_02
    next_mem_req = acc_req;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sel <= `SEL_RESET;
      level <= '0;
      saved_ok <= '0;
      mem_addr <= '0;
      mem_req <= 1'b0;
      active_sel <= `SEL_RESET;
      cur_level <= '0;
    end else begin
      sel <= next_sel;
      level <= next_level;
      saved_ok <= next_saved_ok;
      mem_addr <= next_mem_addr;
      mem_req <= next_mem_req;
      active_sel <= next_sel;
      cur_level <= next_level;
    end
  end

  // The save array has no reset so it can map to RAM. A flag per level tells whether the entry
  // was written since reset, so a level never left before comes back with the reset selection.
  always_ff @(posedge mclk) begin
    if (save_we) begin
      save_mem[level] <= sel; // RULE_04
    end
  end

  property p_load;
    @(posedge mclk) disable iff (sys_rst)
      (op == OP_LOAD_SEL && !level_switch) |=> (active_sel == $past(op_data));
  endproperty
  a_load: assert property (p_load) else $error("load not applied"); // RULE_03

  property p_route;
    @(posedge mclk) disable iff (sys_rst)
      acc_req |=> (mem_addr[12:0] == $past(acc_addr[12:0])) && mem_req;
  endproperty
  a_route: assert property (p_route) else $error("offset not routed"); // RULE_09

  property p_route_mod;
    @(posedge mclk) disable iff (sys_rst)
      acc_req |=> mem_addr[16:13] == $past(sel[acc_addr[14:13]*4 +: 4]);
  endproperty
  a_route_mod: assert property (p_route_mod) else $error("wrong module"); // RULE_02

  property p_restore;
    @(posedge mclk) disable iff (sys_rst)
      (level_switch && new_level != level) ##1 (op == OP_NONE && !level_switch)[*2]
      ##1 (level_switch && new_level == $past(level, 3))
      |=> active_sel == $past(sel, 4);
  endproperty
  a_restore: assert property (p_restore) else $error("selection not restored"); // RULE_05

  property p_level;
    @(posedge mclk) disable iff (sys_rst)
      level_switch |=> cur_level == $past(new_level);
  endproperty
  a_level: assert property (p_level) else $error("level not taken"); // RULE_08

  property p_isolate;
    @(posedge mclk) disable iff (sys_rst)
      (!(level_switch && new_level != level) && saved_ok[new_level])
      |=> save_mem[$past(new_level)] == $past(save_mem[new_level]);
  endproperty
  a_isolate: assert property (p_isolate) else $error("level sel mixed"); // RULE_04

  property p_swap;
    @(posedge mclk) disable iff (sys_rst)
      (op == OP_SWAP_MOD && !level_switch && op_old_mod != op_new_mod)
      |=> active_sel[3:0] != $past(op_old_mod);
  endproperty
  a_swap: assert property (p_swap) else $error("failed module kept"); // RULE_07

  property p_slot;
    @(posedge mclk) disable iff (sys_rst)
      (op == OP_SET_SLOT && !level_switch && op_slot == 2'h3)
      |=> active_sel[15:12] == $past(op_new_mod);
  endproperty
  a_slot: assert property (p_slot) else $error("slot not set"); // RULE_06

  property p_slot_keep;
    @(posedge mclk) disable iff (sys_rst)
      (op == OP_SET_SLOT && !level_switch && op_slot == 2'h3)
      |=> active_sel[11:0] == $past(active_sel[11:0]);
  endproperty
  a_slot_keep: assert property (p_slot_keep) else $error("other slot changed"); // RULE_06

  property p_save;
    @(posedge mclk) disable iff (sys_rst)
      (level_switch && new_level != level)
      |=> saved_ok[$past(level)] && save_mem[$past(level)] == $past(sel);
  endproperty
  a_save: assert property (p_save) else $error("selection not saved"); // RULE_05

  property p_fresh;
    @(posedge mclk) disable iff (sys_rst)
      (level_switch && new_level != level && !saved_ok[new_level])
      |=> active_sel == `SEL_RESET;
  endproperty
  a_fresh: assert property (p_fresh) else $error("fresh level not defaulted"); // RULE_08

  property p_hold;
    @(posedge mclk) disable iff (sys_rst)
      (op == OP_NONE && !level_switch)
      |=> active_sel == $past(active_sel);
  endproperty
  a_hold: assert property (p_hold) else $error("selection drifted"); // RULE_04

  property p_idle;
    @(posedge mclk) disable iff (sys_rst)
      !acc_req |=> !mem_req;
  endproperty
  a_idle: assert property (p_idle) else $error("access without request"); // RULE_02

  // Every slot is watched, since a swap may hit any of them.
  for (genvar g = 0; g < `SLOTS; g++) begin : g_swap_chk
    property p_swap_slot;
      @(posedge mclk) disable iff (sys_rst)
        (op == OP_SWAP_MOD && !level_switch && op_old_mod != op_new_mod)
        |=> active_sel[g*`MOD_NUM_W +: `MOD_NUM_W] != $past(op_old_mod);
    endproperty
    a_swap_slot: assert property (p_swap_slot) else $error("failed module kept"); // RULE_07
  end

  c_switch: cover property (@(posedge mclk) disable iff (sys_rst) level_switch);
  c_swap: cover property (@(posedge mclk) disable iff (sys_rst) op == OP_SWAP_MOD);
  c_load_acc: cover property (@(posedge mclk) disable iff (sys_rst)
    op == OP_LOAD_SEL ##1 acc_req);
  c_restore: cover property (@(posedge mclk) disable iff (sys_rst)
    level_switch && new_level != level && saved_ok[new_level]);
  c_slot: cover property (@(posedge mclk) disable iff (sys_rst) op == OP_SET_SLOT);
endmodule
`default_nettype wire

// File: verification/mem_bank_model.sv
`timescale 1ns/1ps
`default_nettype none
// Decodes which of the sixteen modules an access selects.
module mem_bank_model (
  input wire logic mem_req,
  input wire logic [16:0] mem_addr,
  output logic [3:0] hit_mod
);
  assign hit_mod = mem_req ? mem_addr[16:13] : 4'h0;
endmodule
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
  import bank_sel_pkg::*;
  logic mclk = 0, sys_rst = 1, level_switch = 0, acc_req = 0, mem_req;
  sel_op_t op = OP_NONE;
  logic [15:0] op_data = 16'h0, active_sel, exp_sel, d;
  logic [3:0] op_old_mod = 4'h0, op_new_mod = 4'h0, hit_mod;
  logic [1:0] op_slot = 2'h0;
  level_t new_level = 6'h0, lvl;
  logic [14:0] acc_addr = 15'h0;
  logic [16:0] mem_addr;
  logic [5:0] cur_level;
  logic [15:0] saved [64];
  logic [1:0] kind;
  int error_cnt = 0, compares = 0, cycles = 0, seed = 32'h23f2, i;
  always #10 mclk = ~mclk;
  bank_select bank_select_inst (.mclk(mclk), .sys_rst(sys_rst), .op(op), .op_data(op_data),
    .op_old_mod(op_old_mod), .op_new_mod(op_new_mod), .op_slot(op_slot),
    .level_switch(level_switch), .new_level(new_level), .acc_req(acc_req),
    .acc_addr(acc_addr), .mem_addr(mem_addr), .mem_req(mem_req),
    .active_sel(active_sel), .cur_level(cur_level));
  mem_bank_model mem_bank_model_inst (.mem_req(mem_req), .mem_addr(mem_addr), .hit_mod(hit_mod));
  function automatic logic [15:0] swap(logic [15:0] s, logic [3:0] o, logic [3:0] n);
    for (int k = 0; k < 4; k++) if (s[k*4+:4] == o) s[k*4+:4] = n;
    return s;
  endfunction
  task automatic step;
    @(posedge mclk);
    @(negedge mclk);
    op = OP_NONE;
    level_switch = 0;
    acc_req = 0;
    `CHK(active_sel, exp_sel)
  endtask
  task automatic go(input level_t l);
    saved[lvl] = exp_sel;
    lvl = l;
    exp_sel = saved[l];
    new_level = l;
    level_switch = 1;
    step;
    `CHK(cur_level, lvl)
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 3000) begin
      error_cnt++;
      final_report;
    end
  end
  initial begin
    repeat (20) @(negedge mclk);
    sys_rst = 0;
    exp_sel = 16'h3210;
    `CHK(cur_level, 6'h0)
    for (i = 0; i < 64; i++) begin
      new_level = level_t'(i);
      level_switch = 1;
      op = OP_LOAD_SEL;
      op_data = $random(seed);
      if (i == 0) exp_sel = op_data;
      @(posedge mclk);
      @(negedge mclk);
      `CHK(cur_level, new_level)
      op_data = $random(seed);
      exp_sel = op_data;
      op = OP_LOAD_SEL;
      step;
      saved[i] = exp_sel;
    end
    lvl = 6'h3f;
    exp_sel = 16'h5555;
    op_data = exp_sel;
    op = OP_LOAD_SEL;
    step;
    for (i = 0; i < 300; i++) begin
      d = $random(seed);
      op_old_mod = (i < 2) ? 4'h5 : exp_sel[d[1:0]*4+:4];
      op_new_mod = d[7:4];
      op_slot = d[9:8];
      new_level = d[15:10];
      acc_addr = {d[3:2], d[12:0]};
      kind = d[11:10];
      case (kind)
        2'h0: begin
          op = OP_SWAP_MOD;
          exp_sel = swap(exp_sel, op_old_mod, op_new_mod);
        end
        2'h1: begin
          op = OP_SET_SLOT;
          exp_sel[op_slot*4+:4] = op_new_mod;
        end
        2'h2: begin
          level_switch = 1;
          saved[lvl] = exp_sel;
          lvl = new_level;
          exp_sel = saved[lvl];
        end
        default: acc_req = 1;
      endcase
      d = exp_sel;
      step;
      `CHK(cur_level, lvl)
      `CHK(mem_req, kind == 2'h3)
      if (kind == 2'h3) begin
        `CHK(mem_addr, {d[acc_addr[14:13]*4+:4], acc_addr[12:0]})
        `CHK(hit_mod, d[acc_addr[14:13]*4+:4])
      end
    end
    // Leave a level for two idle cycles and come back: its selection must return.
    i = lvl;
    go(lvl ^ 6'h01);
    step;
    step;
    go(level_t'(i));
    // A reset in mid-run drops every saved selection back to the default.
    sys_rst = 1;
    @(negedge mclk);
    `CHK(active_sel, 16'h3210)
    `CHK(cur_level, 6'h0)
    `CHK(mem_req, 1'b0)
    sys_rst = 0;
    for (i = 0; i < 64; i++) saved[i] = 16'h3210;
    lvl = 6'h00;
    exp_sel = 16'h3210;
    go(6'h2a);
    exp_sel = 16'h9a6c;
    op_data = exp_sel;
    op = OP_LOAD_SEL;
    step;
    go(6'h00);
    go(6'h2a);
    final_report;
  end
endmodule
`default_nettype wire
